//--- ils_pkg.sv
package ils_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_CTRL     = 12'h000;
  localparam logic [11:0] ADDR_CHAN_CFG = 12'h004;
  localparam logic [11:0] ADDR_CHAN_IN  = 12'h008;
  localparam logic [11:0] ADDR_CHAN_LOW = 12'h00C;
  localparam logic [11:0] ADDR_STATUS   = 12'h010;
  localparam logic [11:0] ADDR_INT_STAT = 12'h014;
  localparam logic [11:0] ADDR_INT_EN   = 12'h018;
  localparam logic [11:0] ADDR_INT_CLR  = 12'h01C;
  localparam logic [11:0] ADDR_FAULTS   = 12'h020;

  // ----------------------------------------------------------------
  // Control field positions
  // ----------------------------------------------------------------
  localparam int CTRL_CONFIGURED = 0;
  localparam int CTRL_DISABLE    = 1;
  localparam int CTRL_WDOG_FAIL  = 2;

  // ----------------------------------------------------------------
  // Interrupt status field positions
  // ----------------------------------------------------------------
  localparam int IRQ_PWRUP_DONE  = 0;
  localparam int IRQ_SUPV_FAULT  = 1;
  localparam int IRQ_DRV_FAULT   = 2;
  localparam int IRQ_WIDTH       = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam longint CLK_HZ         = 20000000;
  localparam longint STEP_MS        = 100;
  localparam longint FLASH_HALF_MS  = 500;
  localparam longint ADDR_SHOW_MS   = 2000;
  localparam longint BLINK_MS       = 250;
  localparam int     STEP_CYC       = int'(CLK_HZ * STEP_MS / 1000);
  localparam int     FLASH_HALF_CYC = int'(CLK_HZ * FLASH_HALF_MS / 1000);
  localparam int     ADDR_SHOW_CYC  = int'(CLK_HZ * ADDR_SHOW_MS / 1000);
  localparam int     BLINK_CYC      = int'(CLK_HZ * BLINK_MS / 1000);

  typedef enum logic [3:0] {
    ILS_ST_PWR_IND,
    ILS_ST_RED_ON,
    ILS_ST_RED_OFF,
    ILS_ST_YEL_ON,
    ILS_ST_YEL_OFF,
    ILS_ST_ADDR,
    ILS_ST_RUN
  } ils_state_e;

endpackage

//--- ils_led_sequencer.sv
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/10ps
// Operation
// - After reset the power lamp and device fault lamp light together first.
// - The red channel lamps then turn on one by one from channel 1 to 8.
// - With channel 8 lit, the red lamps turn off one by one from channel 1 to 8.
// - The yellow channel lamps then get the same on sweep and off sweep.
// - Next the red lamps show the address switches, switch n on channel n.
// - The address pattern stays up for two seconds.
// - When the address display ends, the device fault lamp goes off.
// - Unconfigured, all yellow channel lamps flash together at one rate.
// - A supervised channel with a fault lights its yellow lamp and fault flag.
// - A failed positive or negative driver test lights yellow and sets the flag.
// - The green power lamp is dark in reset, lights on the first clock after reset and then stays lit.
// - The device fault lamp holds steady while disabled or after a watchdog failure.
// - The device fault lamp blinks exactly once during power-up.
// - In normal running a red lamp follows its closed input or active output.
// - Yellow blinks for low power or bad configuration, and is steady for a fault.
module ils_led_sequencer #(
  parameter int ADDR_SHOW_CYCLES  = ils_pkg::ADDR_SHOW_CYC,
  parameter int STEP_CYCLES       = ils_pkg::STEP_CYC,
  parameter int FLASH_HALF_CYCLES = ils_pkg::FLASH_HALF_CYC,
  parameter int BLINK_CYCLES      = ils_pkg::BLINK_CYC
) (
  input  wire logic        pclk,            // System clock
  input  wire logic        presetn,         // Async reset, low
  input  wire logic        psel,            // APB select
  input  wire logic        penable,         // APB enable
  input  wire logic        pwrite,          // APB direction
  input  wire logic [11:0] paddr,           // APB address
  input  wire logic [31:0] pwdata,          // APB write data
  output logic      [31:0] prdata,          // APB read data
  output logic             pready,          // APB ready
  output logic             pslverr,         // APB error
  input  wire logic [7:0]  addr_sw,         // Address switches, async
  input  wire logic [7:0]  supv_fault,      // Supervision faults, async
  input  wire logic [7:0]  drv_pos_fail,    // Positive driver test fail, async
  input  wire logic [7:0]  drv_neg_fail,    // Negative driver test fail, async
  output logic      [7:0]  led_red,         // Channel active lamps
  output logic      [7:0]  led_yel,         // Channel fault lamps
  output logic             led_pwr,         // Green power lamp
  output logic             led_dev_fault,   // Yellow device lamp
  output logic      [7:0]  chan_fault,      // Channel fault flags
  output logic             irq              // Level interrupt
);
  import ils_pkg::*;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [31:0] sync1_ff;
  logic [31:0] sync2_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff <= 32'h0000_0000;
      sync2_ff <= 32'h0000_0000;
    end else begin
      // Packed: negative, positive, supervision, switches
      sync1_ff <= {drv_neg_fail, drv_pos_fail, supv_fault, addr_sw};
      sync2_ff <= sync1_ff;
    end
  end

  logic [7:0] sw_s;
  logic [7:0] supv_s;
  logic [7:0] dpos_s;
  logic [7:0] dneg_s;
  assign sw_s   = sync2_ff[7:0];
  assign supv_s = sync2_ff[15:8];
  assign dpos_s = sync2_ff[23:16];
  assign dneg_s = sync2_ff[31:24];

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [2:0]           ctrl_ff;
  logic [7:0]           cfg_ff;
  logic [7:0]           in_ff;
  logic [7:0]           low_ff;
  logic [IRQ_WIDTH-1:0] int_stat_ff;
  logic [IRQ_WIDTH-1:0] int_en_ff;

  logic wr_en;
  assign wr_en = psel && penable && pwrite;

  function automatic logic addr_known(input logic [11:0] a);
    case (a)
      ADDR_CTRL, ADDR_CHAN_CFG, ADDR_CHAN_IN, ADDR_CHAN_LOW, ADDR_STATUS,
      ADDR_INT_STAT, ADDR_INT_EN, ADDR_INT_CLR, ADDR_FAULTS: begin
        addr_known = 1'b1;
      end
      default: begin
        addr_known = 1'b0;
      end
    endcase
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff   <= CTRL_RESET;
      cfg_ff    <= BYTE_RESET;
      in_ff     <= BYTE_RESET;
      low_ff    <= BYTE_RESET;
      int_en_ff <= '0;
    end else if (wr_en) begin
      case (paddr)
        ADDR_CTRL:     ctrl_ff   <= pwdata[2:0];
        ADDR_CHAN_CFG: cfg_ff    <= pwdata[7:0];
        ADDR_CHAN_IN:  in_ff     <= pwdata[7:0];
        ADDR_CHAN_LOW: low_ff    <= pwdata[7:0];
        ADDR_INT_EN:   int_en_ff <= pwdata[IRQ_WIDTH-1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------
  ils_state_e state_ff;
  logic [31:0] tmr_ff;
  logic [2:0]  chan_ff;
  logic [31:0] flash_ff;
  logic        flash_ph_ff;

  logic        flash_tick;
  logic        tmr_done;
  logic [31:0] tmr_limit;

  function automatic logic is_running(input ils_state_e st);
    is_running = (st == ILS_ST_RUN);
  endfunction

  function automatic logic sweep_last(input logic [2:0] ch);
    sweep_last = (ch == 3'h7);
  endfunction

  always_comb begin
    case (state_ff)
      ILS_ST_PWR_IND: tmr_limit = 32'(2 * BLINK_CYCLES - 1);
      ILS_ST_ADDR:    tmr_limit = 32'(ADDR_SHOW_CYCLES - 1);
      default:        tmr_limit = 32'(STEP_CYCLES - 1);
    endcase
  end

  assign tmr_done   = (tmr_ff >= tmr_limit);
  assign flash_tick = (flash_ff >= 32'(FLASH_HALF_CYCLES - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_ff    <= 32'h0000_0000;
      flash_ph_ff <= 1'b0;
    end else if (flash_tick) begin
      flash_ff    <= 32'h0000_0000;
      flash_ph_ff <= !flash_ph_ff;
    end else begin
      flash_ff <= flash_ff + 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------
  // Power-up sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ILS_ST_PWR_IND;
      tmr_ff   <= 32'h0000_0000;
      chan_ff  <= 3'h0;
    end else if (!is_running(state_ff)) begin
      if (!tmr_done) begin
        tmr_ff <= tmr_ff + 32'h0000_0001;
      end else begin
        tmr_ff  <= 32'h0000_0000;
        chan_ff <= chan_ff + 3'h1;
        case (state_ff)
          ILS_ST_PWR_IND: begin
            chan_ff  <= 3'h0;
            state_ff <= ILS_ST_RED_ON;
          end
          ILS_ST_RED_ON: begin
            if (sweep_last(chan_ff)) begin
              state_ff <= ILS_ST_RED_OFF;
            end
          end
          ILS_ST_RED_OFF: begin
            if (sweep_last(chan_ff)) begin
              state_ff <= ILS_ST_YEL_ON;
            end
          end
          ILS_ST_YEL_ON: begin
            if (sweep_last(chan_ff)) begin
              state_ff <= ILS_ST_YEL_OFF;
            end
          end
          ILS_ST_YEL_OFF: begin
            if (sweep_last(chan_ff)) begin
              state_ff <= ILS_ST_ADDR;
            end
          end
          ILS_ST_ADDR: begin
            state_ff <= ILS_ST_RUN;
          end
          default:        state_ff <= ILS_ST_RUN;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Lamp and flag generation
  // ----------------------------------------------------------------
  logic [7:0] sweep_mask;
  logic [7:0] supv_now;
  logic [7:0] drv_now;
  logic [7:0] fault_now;
  logic [7:0] nxt_red;
  logic [7:0] nxt_yel;
  logic       nxt_dev;

  // Lamps 0..chan_ff inclusive
  assign sweep_mask = 8'((9'h002 << chan_ff) - 9'h001);
  assign supv_now   = supv_s & cfg_ff;
  assign drv_now    = dpos_s | dneg_s;
  assign fault_now  = supv_now | drv_now;

  always_comb begin
    nxt_red = 8'h00;
    nxt_yel = 8'h00;
    nxt_dev = 1'b0;
    case (state_ff)
      // Both lamps lit, device lamp blinks once
      ILS_ST_PWR_IND: nxt_dev = (tmr_ff < 32'(BLINK_CYCLES));
      ILS_ST_RED_ON: begin
        nxt_dev = 1'b1;
        nxt_red = sweep_mask;
      end
      ILS_ST_RED_OFF: begin
        nxt_dev = 1'b1;
        nxt_red = ~sweep_mask;
      end
      ILS_ST_YEL_ON: begin
        nxt_dev = 1'b1;
        nxt_yel = sweep_mask;
      end
      ILS_ST_YEL_OFF: begin
        nxt_dev = 1'b1;
        nxt_yel = ~sweep_mask;
      end
      ILS_ST_ADDR: begin
        nxt_dev = 1'b1;
        nxt_red = sw_s;
      end
      ILS_ST_RUN: begin
        nxt_dev = ctrl_ff[CTRL_DISABLE] || ctrl_ff[CTRL_WDOG_FAIL];
        nxt_red = in_ff;
        if (!ctrl_ff[CTRL_CONFIGURED]) begin
          nxt_yel = {8{flash_ph_ff}};
        end else begin
          // Steady fault, blink for low power
          nxt_yel = fault_now | (low_ff & {8{flash_ph_ff}});
        end
      end
      default: ;
    endcase
  end

  logic run_entry;
  assign run_entry = (state_ff == ILS_ST_ADDR) && tmr_done;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      led_red       <= 8'h00;
      led_yel       <= 8'h00;
      led_dev_fault <= 1'b0;
      led_pwr       <= 1'b0;
      chan_fault    <= 8'h00;
    end else begin
      // Lamps lag the state by one cycle
      led_red       <= nxt_red;
      led_yel       <= nxt_yel;
      led_dev_fault <= nxt_dev;
      led_pwr       <= 1'b1;
      chan_fault    <= is_running(state_ff) ? fault_now : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  logic [IRQ_WIDTH-1:0] irq_set;
  logic [IRQ_WIDTH-1:0] irq_clr;
  logic                 clr_hit;
  logic [7:0]           supv_prev_ff;
  logic [7:0]           drv_prev_ff;

  // Separate histories for supervision faults and for positive and negative driver fails combined
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      supv_prev_ff <= 8'h00;
      drv_prev_ff  <= 8'h00;
    end else begin
      supv_prev_ff <= supv_now;
      drv_prev_ff  <= drv_now;
    end
  end

  always_comb begin
    irq_set                 = '0;
    irq_set[IRQ_PWRUP_DONE] = run_entry;
    irq_set[IRQ_SUPV_FAULT] = |(supv_now & ~supv_prev_ff) && is_running(state_ff);
    irq_set[IRQ_DRV_FAULT]  = |(drv_now & ~drv_prev_ff) && is_running(state_ff);
  end

  assign clr_hit = wr_en && (paddr == ADDR_INT_CLR);
  assign irq_clr = clr_hit ? pwdata[IRQ_WIDTH-1:0] : '0;

  // Set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat_ff <= '0;
      irq         <= 1'b0;
    end else begin
      int_stat_ff <= (int_stat_ff & ~irq_clr) | irq_set;
      irq         <= |(((int_stat_ff & ~irq_clr) | irq_set) & int_en_ff);
    end
  end

  // ----------------------------------------------------------------
  // APB read path
  // ----------------------------------------------------------------
  logic [31:0] status_word;

  // Bit 8 running, bits 7:4 state, bit 0 device lamp
  assign status_word = {23'h00_0000, is_running(state_ff), state_ff, 3'h0, led_dev_fault};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !addr_known(paddr);
      prdata  <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          ADDR_CTRL:     prdata <= {29'h0, ctrl_ff};
          ADDR_CHAN_CFG: prdata <= {24'h0, cfg_ff};
          ADDR_CHAN_IN:  prdata <= {24'h0, in_ff};
          ADDR_CHAN_LOW: prdata <= {24'h0, low_ff};
          ADDR_STATUS:   prdata <= status_word;
          ADDR_INT_STAT: prdata <= {29'h0, int_stat_ff};
          ADDR_INT_EN:   prdata <= {29'h0, int_en_ff};
          ADDR_FAULTS:   prdata <= {24'h0, chan_fault};
          default:       prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule

//--- ils_led_sequencer_assertions.sv
`timescale 1ns/10ps
module ils_led_sequencer_assertions #(
  parameter int ADDR_SHOW_CYCLES = 20,
  parameter int STEP_CYCLES      = 4,
  parameter int BLINK_CYCLES     = 4
) (
  input wire logic       pclk,          // Clock
  input wire logic       presetn,       // Reset, low
  input wire logic       psel,          // APB select
  input wire logic       penable,       // APB enable
  input wire logic       pready,        // APB ready
  input wire logic [7:0] addr_sw,       // Switches
  input wire logic [7:0] led_red,       // Red lamps
  input wire logic [7:0] led_yel,       // Yellow lamps
  input wire logic       led_pwr,       // Green lamp
  input wire logic       led_dev_fault  // Device lamp
);
  localparam int SW = 2 * BLINK_CYCLES + 32 * STEP_CYCLES;
  localparam int AE = SW + ADDR_SHOW_CYCLES;
  logic [15:0] cyc_ff;
  // ----------------------------
  // Cycles since reset release
  // ----------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_ff <= 16'h0;
    end else if (cyc_ff != 16'hFFFF) begin
      cyc_ff <= cyc_ff + 16'h1;
    end
  end
  // Lit from channel 1 up, or dark from channel 1 up
  function automatic logic therm(input logic [7:0] x);
    return ((x & (x + 8'h1)) == 8'h0) || ((~x & (~x + 8'h1)) == 8'h0);
  endfunction
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_dark;
    ##[2:8] !led_dev_fault;
  endsequence
  a_pwr_lamp_on: assert property (cyc_ff != 16'h0 |-> led_pwr)
    else $error("power lamp dark");
  a_pwrup_first: assert property (cyc_ff inside {[1:3]} |-> led_dev_fault && led_red == 8'h0 && led_yel == 8'h0)
    else $error("power-up lamps wrong");
  a_single_blink: assert property (cyc_ff == 16'h1 |-> s_dark ##[1:6] led_dev_fault)
    else $error("device lamp blink missing");
  a_dev_lit_test: assert property (cyc_ff inside {[2 * BLINK_CYCLES + 2:AE - 2]} |-> led_dev_fault)
    else $error("device lamp dropped early");
  a_sweep_shape: assert property (cyc_ff inside {[1:SW - 2]} |-> therm(led_red) && therm(led_yel) && (led_red == 8'h0 || led_yel == 8'h0))
    else $error("lamp sweep out of order");
  a_addr_shown: assert property (cyc_ff inside {[SW + 4:AE - 2]} |-> led_red == addr_sw && led_yel == 8'h0)
    else $error("address pattern wrong");
  a_addr_end: assert property (cyc_ff == AE - 3 |-> led_dev_fault ##6 !led_dev_fault)
    else $error("device lamp not cleared");
  a_ready_access: assert property (psel && !penable |=> pready && psel && penable)
    else $error("ready missing in access");
  a_ready_only: assert property (pready |-> psel && penable && $past(psel) && !$past(penable))
    else $error("ready outside access");
endmodule
bind ils_led_sequencer ils_led_sequencer_assertions #(
  .ADDR_SHOW_CYCLES(ADDR_SHOW_CYCLES),
  .STEP_CYCLES     (STEP_CYCLES),
  .BLINK_CYCLES    (BLINK_CYCLES)
) chk_u (
  .pclk, .presetn, .psel, .penable, .pready, .addr_sw,
  .led_red, .led_yel, .led_pwr, .led_dev_fault
);

//--- ils_panel_model.sv
`timescale 1ns/10ps
module ils_panel_model #(
  parameter logic [7:0] SW_SETTING = 8'hA5
) (
  input  wire logic       pclk,          // Clock
  input  wire logic       led_dev_fault, // Device lamp
  output logic      [7:0] addr_sw,       // Switches
  output logic      [7:0] supv_fault,    // Supervision faults
  output logic      [7:0] drv_pos_fail,  // Positive driver fails
  output logic      [7:0] drv_neg_fail,  // Negative driver fails
  output int              dev_falls      // Device lamp turn-offs
);
  logic dev_ff = 1'b0;
  // Switches set before power and never moved
  initial begin
    addr_sw = SW_SETTING;
    supv_fault = 8'h0;
    drv_pos_fail = 8'h0;
    drv_neg_fail = 8'h0;
    dev_falls = 0;
  end
  always @(posedge pclk) begin
    if (dev_ff && !led_dev_fault) begin
      dev_falls <= dev_falls + 1;
    end
    dev_ff <= led_dev_fault;
  end
  task automatic set_faults(input logic [7:0] s, input logic [7:0] p, input logic [7:0] n);
    @(posedge pclk);
    supv_fault <= s;
    drv_pos_fail <= p;
    drv_neg_fail <= n;
  endtask
endmodule

//--- ils_led_sequencer_tb.sv
`timescale 1ns/10ps
module ils_led_sequencer_tb;
  import ils_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic        led_pwr, led_dev_fault, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  addr_sw, supv_fault, drv_pos_fail, drv_neg_fail;
  logic [7:0]  led_red, led_yel, chan_fault, rp, yp, e;
  logic [7:0]  rq[$], yq[$];
  logic [31:0] cv [3] = '{32'h3, 32'h5, 32'h1};
  int          err_count, checked, cyc, dev_falls, n0, n1;

  ils_led_sequencer #(
    .ADDR_SHOW_CYCLES (20),
    .STEP_CYCLES      (4),
    .FLASH_HALF_CYCLES(8),
    .BLINK_CYCLES     (4)
  ) dut_u (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .addr_sw, .supv_fault, .drv_pos_fail, .drv_neg_fail, .led_red,
    .led_yel, .led_pwr, .led_dev_fault, .chan_fault, .irq
  );
  ils_panel_model panel_u (
    .pclk, .led_dev_fault, .addr_sw, .supv_fault, .drv_pos_fail, .drv_neg_fail,
    .dev_falls
  );

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // ----------------------------------
  // Lamp history and hang limit
  // ----------------------------------
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (presetn && cyc < 220) begin
      if (led_red !== rp) rq.push_back(led_red);
      if (led_yel !== yp) yq.push_back(led_yel);
      rp <= led_red;
      yp <= led_yel;
    end
    if (cyc == 2000) begin
      err_count++;
      summarize();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic count_yel(input logic [7:0] m);
    n0 = 0;
    n1 = 0;
    repeat (40) begin
      @(posedge pclk);
      if ((led_yel & m) === m) n1++;
      else if ((led_yel & m) === 8'h0) n0++;
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
    {err_count, checked, cyc, rp, yp} = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk({led_pwr, led_dev_fault, led_red, led_yel}, 32'h3_0000);
    xfer(1'b0, ADDR_CTRL, 32'h0);
    chk(rd, 32'h0);
    wait (cyc == 210);
    chk(rq.size(), 18);
    for (int k = 0; k < 8; k++) begin
      e = 8'hFF >> (7 - k);
      chk(rq[k], e);
      chk(yq[k], e);
      e = 8'hFF << (k + 1);
      chk(rq[k + 8], e);
      chk(yq[k + 8], e);
    end
    chk(rq[16], 8'hA5);
    chk(dev_falls, 2);
    $display("test powerup ended");
    count_yel(8'hFF);
    chk(n0 + n1, 40);
    chk(n0 > 12 && n1 > 12, 1);
    xfer(1'b1, ADDR_CTRL, 32'h1);
    xfer(1'b1, ADDR_CHAN_IN, 32'h3C);
    repeat (3) @(posedge pclk);
    chk({led_red, led_yel}, 16'h3C00);
    $display("test run ended");
    xfer(1'b1, ADDR_CHAN_CFG, 32'h1);
    xfer(1'b1, ADDR_INT_EN, 32'h6);
    panel_u.set_faults(8'h03, 8'h00, 8'h00);
    repeat (6) @(posedge pclk);
    chk({chan_fault, led_yel, 7'h0, irq}, 32'h0101_01);
    xfer(1'b0, ADDR_INT_STAT, 32'h0);
    chk(rd, 32'h3);
    xfer(1'b1, ADDR_INT_CLR, 32'h7);
    xfer(1'b1, ADDR_INT_EN, 32'h0);
    panel_u.set_faults(8'h03, 8'h10, 8'h80);
    repeat (6) @(posedge pclk);
    chk({chan_fault, led_yel, 7'h0, irq}, 32'h9191_00);
    xfer(1'b1, ADDR_INT_EN, 32'h4);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b1);
    xfer(1'b1, ADDR_INT_CLR, 32'h7);
    xfer(1'b1, ADDR_INT_EN, 32'h0);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0);
    $display("test faults ended");
    xfer(1'b1, ADDR_CHAN_LOW, 32'h40);
    count_yel(8'h91);
    chk(n1, 40);
    count_yel(8'h40);
    chk(n0 > 12 && n1 > 12, 1);
    $display("test blink ended");
    for (int i = 0; i < 3; i++) begin
      xfer(1'b1, ADDR_CTRL, cv[i]);
      repeat (3) @(posedge pclk);
      chk(led_dev_fault, cv[i] != 32'h1);
    end
    xfer(1'b0, ADDR_STATUS, 32'h0);
    chk(rd, 32'h0000_0100 | (32'(ILS_ST_RUN) << 4));
    $display("test device ended");
    xfer(1'b1, ADDR_FAULTS, 32'h0);
    xfer(1'b0, ADDR_FAULTS, 32'h0);
    chk(rd, 32'h91);
    xfer(1'b0, 12'h024, 32'h0);
    chk({er, rd[30:0]}, 32'h8000_0000);
    $display("test bus ended");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({led_pwr, led_dev_fault, led_red, led_yel, chan_fault, irq}, 32'h0);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    chk({led_pwr, led_dev_fault}, 2'b11);
    $display("test reset ended");
    summarize();
  end
endmodule
